//--- ctm_cfg.svh
`ifndef CTM_CFG_SVH
`define CTM_CFG_SVH

// Register byte addresses on the APB bus.
`define CTM_ADDR_W          12
`define CTM_CHMAP_OFS       12'h000
`define CTM_STATUS_OFS      12'h004

// Channel map register fields.
`define CTM_CHMAP_W         16
`define CTM_CHMAP_RESET     16'h0001
`define CTM_CHMAP_WMASK     16'hb3ff
`define CTM_EN_BIT          15
`define CTM_SETUP_HI        13
`define CTM_SETUP_LO        12
`define CTM_POS_HI          9
`define CTM_POS_LO          5
`define CTM_NEG_HI          4
`define CTM_NEG_LO          0

// Status register fields.
`define CTM_ST_BUSY_BIT     0
`define CTM_ST_CH_HI        2
`define CTM_ST_CH_LO        1
`define CTM_ST_CH3_BIT      3
`define CTM_ST_SETUP_HI     5
`define CTM_ST_SETUP_LO     4
`define CTM_ST_POS_HI       10
`define CTM_ST_POS_LO       6
`define CTM_ST_NEG_HI       15
`define CTM_ST_NEG_LO       11

// Multiplexer selector codes.
`define CTM_SEL_ANALOG_IN_ZERO        5'h00
`define CTM_SEL_ANALOG_IN_ONE        5'h01
`define CTM_SEL_ANALOG_IN_TWO        5'h02
`define CTM_SEL_ANALOG_IN_THREE        5'h03
`define CTM_SEL_ANALOG_IN_FOUR        5'h04
`define CTM_SEL_REFP        5'h15

// Reset view of the state captured at a conversion start.
`define CTM_SETUP_RESET     2'h0
`define CTM_POS_RESET       5'h00
`define CTM_NEG_RESET       5'h01
`define CTM_POS_ROUTE_RESET 6'h01
`define CTM_NEG_ROUTE_RESET 6'h02

// This logic controls channel index 3 of four.
`define CTM_OWN_CHAN        2'h3

`endif

//--- ctm_pkg.sv
package ctm_pkg;
  typedef enum logic [0:0] {
    CTM_IDLE = 1'b0,
    CTM_CONV = 1'b1
  } ctm_seq_state_t;

  typedef logic [1:0] ctm_chan_t;
  typedef logic [1:0] ctm_setup_t;
  typedef logic [4:0] ctm_sel_t;
  // One-hot terminal route: bits 0..4 analog inputs, bit 5 positive reference.
  typedef logic [5:0] ctm_route_t;
endpackage : ctm_pkg

//--- ctm_seq_if.sv
`timescale 1ns/10ps
interface ctm_seq_if;
  import ctm_pkg::*;
  logic [3:0] chan_enables;
  logic       conv_done;
  logic       conv_start;
  ctm_chan_t  active_chan;
  logic       busy;

  modport seq (
    input  chan_enables,
    input  conv_done,
    output conv_start,
    output active_chan,
    output busy
  );
  modport ctrl (
    output chan_enables,
    output conv_done,
    input  conv_start,
    input  active_chan,
    input  busy
  );
endinterface : ctm_seq_if

//--- ctm_seq.sv
`timescale 1ns/10ps
`include "ctm_cfg.svh"
module ctm_seq (
  // Clock and reset.
  input  wire logic  pclk,
  input  wire logic  presetn,
  // Sequencing handshake.
  ctm_seq_if.seq     sif
);
  import ctm_pkg::*;

  ctm_seq_state_t state_q, state_d;
  ctm_chan_t      chan_q, chan_d;
  logic           start_q, start_d;

  // Finds the first enabled channel after cur, wrapping, cur itself last.
  function automatic ctm_chan_t next_enabled(input ctm_chan_t cur, input logic [3:0] en);
    ctm_chan_t res;
    ctm_chan_t cand;
    res = cur;
    for (int k = 4; k >= 1; k--) begin
      cand = ctm_chan_t'(cur + ctm_chan_t'(k));
      if (en[cand]) begin
        res = cand;
      end
    end
    return res;
  endfunction : next_enabled

  always_comb begin
    state_d = state_q;
    chan_d  = chan_q;
    start_d = 1'b0;
    unique case (state_q)
      CTM_IDLE: begin
        if (|sif.chan_enables) begin
          state_d = CTM_CONV;
          chan_d  = next_enabled(`CTM_OWN_CHAN, sif.chan_enables);
          start_d = 1'b1;
        end
      end
      CTM_CONV: begin
        if (sif.conv_done) begin
          if (|sif.chan_enables) begin
            chan_d  = next_enabled(chan_q, sif.chan_enables);
            start_d = 1'b1;
          end else begin
            state_d = CTM_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= CTM_IDLE;
      chan_q  <= 2'h0;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      chan_q  <= chan_d;
      start_q <= start_d;
    end
  end

  assign sif.conv_start  = start_q;
  assign sif.active_chan = chan_q;
  assign sif.busy        = (state_q == CTM_CONV);
endmodule : ctm_seq

//--- ctm_top.sv
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "ctm_cfg.svh"
module ctm_top (
  // Clock and reset.
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave.
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Other channels and converter, same clock.
  input  wire logic [2:0]         other_chan_enables,
  input  wire logic               conv_done,
  output logic                    conv_start,
  output ctm_pkg::ctm_chan_t      active_channel,
  // Applied configuration for this channel.
  output logic                    chan3_enable,
  output logic                    chan3_converting,
  output ctm_pkg::ctm_setup_t     setup_index,
  output ctm_pkg::ctm_route_t     pos_route,
  output ctm_pkg::ctm_route_t     neg_route
);
  import ctm_pkg::*;

  ctm_seq_if sif ();

  // Register bus state.
  logic [15:0] chmap_q, chmap_d;
  logic [31:0] rdata_q, rdata_d;
  // State captured at this channel's conversion start.
  ctm_setup_t  setup_q, setup_d;
  ctm_sel_t    pos_q, pos_d;
  ctm_sel_t    neg_q, neg_d;
  ctm_route_t  pos_route_q, pos_route_d;
  ctm_route_t  neg_route_q, neg_route_d;
  logic        ch3_q, ch3_d;
  // Bus decode and status view.
  logic        wr_en;
  logic        rd_setup;
  logic        mapped;
  logic        own_start;
  logic [31:0] status;

  // Decodes a selector code to a one-hot terminal route; unlisted codes route nothing.
  function automatic ctm_route_t route_of(input ctm_sel_t sel);
    ctm_route_t r;
    r = 6'h00;
    unique case (sel)
      `CTM_SEL_ANALOG_IN_ZERO: r = 6'h01;
      `CTM_SEL_ANALOG_IN_ONE: r = 6'h02;
      `CTM_SEL_ANALOG_IN_TWO: r = 6'h04;
      `CTM_SEL_ANALOG_IN_THREE: r = 6'h08;
      `CTM_SEL_ANALOG_IN_FOUR: r = 6'h10;
      `CTM_SEL_REFP: r = 6'h20;
      default:       r = 6'h00;
    endcase
    return r;
  endfunction : route_of

  // Address decode, shared by the write strobe, the read mux and the error flag.
  function automatic logic hits_chmap(input logic [11:0] addr);
    return addr == `CTM_CHMAP_OFS;
  endfunction : hits_chmap

  function automatic logic hits_status(input logic [11:0] addr);
    return addr == `CTM_STATUS_OFS;
  endfunction : hits_status

  // Field views of the channel map word.
  function automatic logic chmap_enabled(input logic [15:0] word);
    return word[`CTM_EN_BIT];
  endfunction : chmap_enabled

  function automatic ctm_setup_t chmap_setup(input logic [15:0] word);
    return word[`CTM_SETUP_HI:`CTM_SETUP_LO];
  endfunction : chmap_setup

  function automatic ctm_sel_t chmap_pos(input logic [15:0] word);
    return word[`CTM_POS_HI:`CTM_POS_LO];
  endfunction : chmap_pos

  function automatic ctm_sel_t chmap_neg(input logic [15:0] word);
    return word[`CTM_NEG_HI:`CTM_NEG_LO];
  endfunction : chmap_neg

  // Picks the read word for an address; unmapped addresses read zero.
  function automatic logic [31:0] read_word(
    input logic [11:0] addr,
    input logic [15:0] chmap,
    input logic [31:0] stat
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    if (hits_chmap(addr)) begin
      w = {16'h0000, chmap};
    end else if (hits_status(addr)) begin
      w = stat;
    end
    return w;
  endfunction : read_word

  // Round-robin sequencer over the four channel enables.
  ctm_seq u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (sif.seq)
  );

  assign sif.chan_enables = {chmap_enabled(chmap_q), other_chan_enables};
  assign sif.conv_done    = conv_done;
  assign own_start        = sif.conv_start && (sif.active_chan == `CTM_OWN_CHAN);

  // Register bus: zero wait states, error only on unmapped addresses.
  assign mapped   = hits_chmap(paddr) || hits_status(paddr);
  assign wr_en    = psel && penable && pwrite && hits_chmap(paddr);
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;

  // Status word: busy, channel, own-conversion flag and the captured fields.
  always_comb begin
    status = 32'h0000_0000;
    status[`CTM_ST_BUSY_BIT]                 = sif.busy;
    status[`CTM_ST_CH_HI:`CTM_ST_CH_LO]       = sif.active_chan;
    status[`CTM_ST_CH3_BIT]                  = ch3_q;
    status[`CTM_ST_SETUP_HI:`CTM_ST_SETUP_LO] = setup_q;
    status[`CTM_ST_POS_HI:`CTM_ST_POS_LO]     = pos_q;
    status[`CTM_ST_NEG_HI:`CTM_ST_NEG_LO]     = neg_q;
  end

  // Read data is fetched in the setup cycle so it stands for the whole access phase.
  always_comb begin
    chmap_d = chmap_q;
    rdata_d = rdata_q;
    if (wr_en) begin
      // Reserved bits are dropped so they always read back as zero.
      chmap_d = pwdata[15:0] & `CTM_CHMAP_WMASK;
    end
    if (rd_setup) begin
      rdata_d = read_word(paddr, chmap_q, status);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chmap_q <= `CTM_CHMAP_RESET;
      rdata_q <= 32'h0000_0000;
    end else begin
      chmap_q <= chmap_d;
      rdata_q <= rdata_d;
    end
  end

  // Setup and routing are captured when this channel's conversion starts.
  // A write that lands later waits for the next start of this channel.
  always_comb begin
    setup_d     = setup_q;
    pos_d       = pos_q;
    neg_d       = neg_q;
    pos_route_d = pos_route_q;
    neg_route_d = neg_route_q;
    ch3_d       = ch3_q;
    if (sif.conv_start) begin
      ch3_d = own_start;
      if (own_start) begin
        setup_d     = chmap_setup(chmap_q);
        pos_d       = chmap_pos(chmap_q);
        neg_d       = chmap_neg(chmap_q);
        pos_route_d = route_of(chmap_pos(chmap_q));
        neg_route_d = route_of(chmap_neg(chmap_q));
      end
    end else if (!sif.busy) begin
      // The flag drops once the sequencer has gone idle.
      ch3_d = 1'b0;
    end
  end

  // The reset view matches the channel map reset: input zero against input one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_q     <= `CTM_SETUP_RESET;
      pos_q       <= `CTM_POS_RESET;
      neg_q       <= `CTM_NEG_RESET;
      pos_route_q <= `CTM_POS_ROUTE_RESET;
      neg_route_q <= `CTM_NEG_ROUTE_RESET;
      ch3_q       <= 1'b0;
    end else begin
      setup_q     <= setup_d;
      pos_q       <= pos_d;
      neg_q       <= neg_d;
      pos_route_q <= pos_route_d;
      neg_route_q <= neg_route_d;
      ch3_q       <= ch3_d;
    end
  end

  assign prdata           = rdata_q;
  assign conv_start       = sif.conv_start;
  assign active_channel   = sif.active_chan;
  assign chan3_enable     = chmap_q[`CTM_EN_BIT];
  assign chan3_converting = ch3_q;
  assign setup_index      = setup_q;
  assign pos_route        = pos_route_q;
  assign neg_route        = neg_route_q;
endmodule : ctm_top

//--- ctm_top_properties.sv
`timescale 1ns/10ps
`include "ctm_cfg.svh"
module ctm_top_properties
  import ctm_pkg::*;
(
  // Clock, reset and bus.
  input wire logic pclk, presetn, psel, penable, pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Sequencing.
  input wire logic [2:0] other_chan_enables,
  input wire logic conv_done, conv_start, chan3_enable, chan3_converting,
  input wire ctm_pkg::ctm_chan_t active_channel,
  // Applied configuration.
  input wire ctm_pkg::ctm_setup_t setup_index,
  input wire ctm_pkg::ctm_route_t pos_route, neg_route
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr0 = psel && penable && pwrite && paddr == 12'h000;
  wire st3 = conv_start && active_channel == 2'h3;
  logic [15:0] shadow_q;
  // Mirrors the channel map so the captured setup and routes can be predicted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_q <= `CTM_CHMAP_RESET;
    end else if (wr0) begin
      shadow_q <= pwdata[15:0] & `CTM_CHMAP_WMASK;
    end
  end
  function automatic ctm_route_t exp_route(input ctm_sel_t c);
    ctm_route_t r;
    r = 6'h00;
    if (c <= `CTM_SEL_ANALOG_IN_FOUR) begin
      r = ctm_route_t'(6'h01 << c);
    end else if (c == `CTM_SEL_REFP) begin
      r = 6'h20;
    end
    return r;
  endfunction : exp_route
  AST_EN: assert property (wr0 |=> chan3_enable == $past(pwdata[15]))
    else $error("enable bit not stored");
  AST_NOSTART: assert property (st3 |-> chan3_enable || $past(chan3_enable))
    else $error("disabled channel started");
  AST_GO: assert property (conv_done && (chan3_enable || |other_chan_enables) |=> conv_start)
    else $error("sequencer did not advance");
  AST_CONV: assert property (st3 |=> chan3_converting && setup_index == $past(shadow_q[13:12]))
    else $error("channel not marked converting");
  AST_NCONV: assert property (conv_start && active_channel != 2'h3 |=> !chan3_converting)
    else $error("converting flag held for other channel");
  AST_HOLD: assert property (!st3 |=> $stable(setup_index) && $stable(pos_route) && $stable(neg_route))
    else $error("applied configuration changed between starts");
  AST_POS: assert property (st3 |=> $onehot0(pos_route) && pos_route == exp_route($past(shadow_q[9:5])))
    else $error("positive route not one-hot");
  AST_NEG: assert property (st3 |=> $onehot0(neg_route) && neg_route == exp_route($past(shadow_q[4:0])))
    else $error("negative route not one-hot");
  cover property (st3);
  cover property (conv_start && active_channel == 2'h0);
  cover property (conv_done ##1 conv_start);
endmodule : ctm_top_properties
bind ctm_top ctm_top_properties i_chk (.*);

//--- testbench.sv
`timescale 1ns/10ps
`include "ctm_cfg.svh"
`define CK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; $display("mismatch %0t %h %h", $time, g, e); end end
module testbench;
  import ctm_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, conv_done = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0] other_chan_enables = 3'h0;
  logic pready, pslverr, conv_start, chan3_enable, chan3_converting, er;
  ctm_chan_t active_channel;
  ctm_chan_t ord [4] = '{2'h0, 2'h2, 2'h3, 2'h0};
  ctm_setup_t setup_index, s;
  ctm_route_t pos_route, neg_route;
  ctm_sel_t p, n;
  int n_errors = 0, compares = 0, i;
  always #2 pclk = ~pclk;
  ctm_top i_dut (.*);
  function automatic ctm_route_t rt(ctm_sel_t c);
    return c < 5'h05 ? 6'h01 << c : (c == 5'h15 ? 6'h20 : 6'h00);
  endfunction : rt
  function automatic ctm_sel_t cd(int k);
    return k == 5 ? 5'h15 : ctm_sel_t'(k);
  endfunction : cd
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin n_errors++; complete_run(); end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wcs(input ctm_chan_t ch);
    int k = 0;
    do begin @(posedge pclk); k++; end while (conv_start !== 1'b1 && k < 20);
    if (conv_start !== 1'b1) begin n_errors++; complete_run(); end
    `CK(active_channel, ch)
  endtask : wcs
  task automatic done;
    conv_done <= 1'b1;
    @(posedge pclk);
    conv_done <= 1'b0;
  endtask : done
  initial begin
    void'($urandom(31734));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CTM_CHMAP_OFS, 32'h0);
    `CK(rd, 32'h0000_0001)
    `CK({chan3_enable, chan3_converting, neg_route}, {2'b00, 6'h02})
    apb(1'b1, `CTM_CHMAP_OFS, 32'h0000_8001);
    wcs(2'h3);
    @(posedge pclk);
    `CK({setup_index, pos_route, neg_route}, {2'h0, 6'h01, 6'h02})
    $display("test reset done");
    for (i = 0; i < 12; i++) begin
      s = i[1:0];
      p = i < 6 ? cd(i) : ctm_sel_t'($urandom);
      n = i < 6 ? cd(5 - i) : ctm_sel_t'($urandom);
      apb(1'b1, `CTM_CHMAP_OFS, {16'h0, 1'b1, 1'b0, s, 2'b00, p, n});
      done();
      wcs(2'h3);
      @(posedge pclk);
      `CK({chan3_converting, setup_index, pos_route, neg_route}, {1'b1, s, rt(p), rt(n)})
    end
    $display("test config done");
    other_chan_enables <= 3'b101;
    for (i = 0; i < 4; i++) begin
      done();
      wcs(ord[i]);
    end
    $display("test sequence done");
    other_chan_enables <= 3'b000;
    apb(1'b1, `CTM_CHMAP_OFS, 32'h0);
    done();
    repeat (4) begin @(posedge pclk); `CK(conv_start, 1'b0) end
    `CK(chan3_enable, 1'b0)
    $display("test disable done");
    apb(1'b1, `CTM_CHMAP_OFS, 32'h0000_b3ff);
    apb(1'b0, `CTM_CHMAP_OFS, 32'h0);
    `CK({er, rd}, {1'b0, 32'h0000_b3ff})
    apb(1'b0, `CTM_STATUS_OFS, 32'h0);
    `CK({er, rd}, {1'b0, 32'h0000_ffff})
    apb(1'b0, 12'h008, 32'h0);
    `CK({er, rd}, {1'b1, 32'h0})
    $display("test access done");
    complete_run();
  end
endmodule : testbench
